//--- rtl/programmable_watchdog_counter.sv
`timescale 1ns/1ps
`include "wdog_params.svh"
module programmable_watchdog_counter
    import wdog_pkg::*;
#(
    parameter int PRESCALE = `PRESCALE_CLKS
)(
    // Clock and power-on reset.
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // AXI4-Lite write channels.
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read channels.
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Power state of the core, same clock domain.
    input  wire logic        idle_mode,
    input  wire logic        power_down,
    input  wire logic        clock_gate_off,
    // Chip reset request and interrupt.
    output logic             wdog_reset_req,
    output logic             timeout_irq,
    output logic [15:0]      irq_vector,
    output logic [1:0]       irq_priority
);
    // ==========================================================
    // Register and state storage.
    logic       run_bit_ff;            // Software start/stop.
    logic       force_run_bit_ff;      // Runs regardless of run bit.
    logic       reset_on_timeout_enable_ff; // Watchdog mode select.
    logic       overflow_status_flag_ff;    // Sticky overflow.
    logic       timeout_irq_enable_ff; // Interrupt enable.
    logic [7:0] watchdog_reload_ff;    // Reload value.
    logic [7:0] count_ff;              // Up counter.
    logic [18:0] presc_ff;             // Crystal clock divider.
    logic       rst_hold_ff;           // Reset request active.
    logic [1:0] rst_tick_ff;           // Ticks seen while in reset.
    key_state_t key_ff;                // Key sequence progress.
    // AXI write capture.
    logic       aw_held_ff;
    logic       w_held_ff;
    logic [7:0] waddr_ff;
    logic [7:0] wbyte_ff;
    logic       wen_ff;
    // ==========================================================
    // Decode and combinational terms.
    logic wdog_mode;
    logic running;
    logic tick;
    logic ovf_evt;
    logic wr_go;
    logic wr_ok;
    logic wr_ctl;
    logic ctl_allowed;
    logic key_fault;
    logic refresh;

    // Register decode is used by both the read and write paths.
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == `OFS_CONTROL) || (a == `OFS_RELOAD) ||
                 (a == `OFS_KEY_ONE) || (a == `OFS_KEY_ZERO) ||
                 (a == `OFS_AUX_IRQ);
    endfunction

    assign wdog_mode   = reset_on_timeout_enable_ff;
    // Power-down halts counting in both modes; in timer mode a gated clock also halts it.
    // Idle mode is deliberately not a term here: the count keeps going.
    assign running     = (force_run_bit_ff | run_bit_ff) & ~power_down
                         & ~(clock_gate_off & ~wdog_mode);
    assign tick        = running && (presc_ff == 19'(PRESCALE - 1));
    assign ovf_evt     = tick && (count_ff == `CNT_MAX);
    assign wr_go       = aw_held_ff && w_held_ff && !bvalid;
    assign wr_ok       = wr_go && mapped(waddr_ff) && wen_ff;
    assign wr_ctl      = wr_ok && (waddr_ff == `OFS_CONTROL);
    assign ctl_allowed = !wdog_mode || (key_ff == KEY_ARMED);
    assign refresh     = wr_ctl && ctl_allowed && wbyte_ff[`CTL_REFRESH];
    // Wrong key value, key zero out of order, or an unkeyed control write.
    always_comb
    begin
        key_fault = 1'b0;
        if (wr_ok && wdog_mode)
        begin
            if (waddr_ff == `OFS_KEY_ONE)
                key_fault = (wbyte_ff != `KEY_ONE_VAL);
            else if (waddr_ff == `OFS_KEY_ZERO)
                key_fault = (wbyte_ff != `KEY_ZERO_VAL) || (key_ff != KEY_GOT_ONE);
            else if (waddr_ff == `OFS_CONTROL)
                key_fault = (key_ff != KEY_ARMED);
        end
    end

    // ==========================================================
    // AXI4-Lite write side: address and data are taken in either order.
    assign awready = !aw_held_ff;
    assign wready  = !w_held_ff;
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            waddr_ff   <= 8'h00;
            wbyte_ff   <= 8'h00;
            wen_ff     <= 1'b0;
            bvalid     <= 1'b0;
            bresp      <= `RESP_OKAY;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_held_ff <= 1'b1;
                waddr_ff   <= {awaddr[7:2], 2'b00};
            end
            if (wvalid && wready)
            begin
                w_held_ff <= 1'b1;
                wbyte_ff  <= wdata[7:0];
                wen_ff    <= wstrb[0];
            end
            // Both halves present: perform and answer next cycle.
            if (wr_go)
            begin
                aw_held_ff <= 1'b0;
                w_held_ff  <= 1'b0;
                bvalid     <= 1'b1;
                bresp      <= mapped(waddr_ff) ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (bvalid && bready)
                bvalid <= 1'b0;
        end
    end

    // ==========================================================
    // AXI4-Lite read side: one read at a time, data from flip-flops.
    assign arready = !rvalid;
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= `RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            rvalid <= 1'b1;
            // Decode the aligned word so the answer agrees with the data mux.
            rresp  <= mapped({araddr[7:2], 2'b00}) ? `RESP_OKAY : `RESP_SLVERR;
            rdata  <= 32'h0000_0000;
            unique case ({araddr[7:2], 2'b00})
                `OFS_CONTROL: rdata[7:0] <= {1'b0, force_run_bit_ff, 2'b00,
                    reset_on_timeout_enable_ff, overflow_status_flag_ff,
                    1'b0, run_bit_ff};
                `OFS_RELOAD:  rdata[7:0] <= watchdog_reload_ff;
                `OFS_AUX_IRQ: rdata[`AUX_IRQ_EN] <= timeout_irq_enable_ff;
                // Key registers and holes read as zero.
                default:      rdata[7:0] <= 8'h00;
            endcase
        end
        else if (rvalid && rready)
            rvalid <= 1'b0;
    end

    // ==========================================================
    // Key sequence tracker; any completed or failed attempt starts over.
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            key_ff <= KEY_IDLE;
        else if (wr_ok)
        begin
            if (waddr_ff == `OFS_KEY_ONE && wbyte_ff == `KEY_ONE_VAL)
                key_ff <= KEY_GOT_ONE;
            else if (waddr_ff == `OFS_KEY_ZERO && wbyte_ff == `KEY_ZERO_VAL
                     && key_ff == KEY_GOT_ONE)
                key_ff <= KEY_ARMED;
            else
                key_ff <= KEY_IDLE;
        end
    end

    // ==========================================================
    // Control bits. Reset-enable is sticky: only resetn clears it, so a
    // watchdog reset cannot accidentally drop the chip out of watchdog mode.
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            run_bit_ff                 <= 1'b0;
            force_run_bit_ff           <= 1'b0;
            reset_on_timeout_enable_ff <= 1'b0;
            timeout_irq_enable_ff      <= 1'b0;
            watchdog_reload_ff         <= `RELOAD_RST;
        end
        else if (wr_ok)
        begin
            if (waddr_ff == `OFS_CONTROL && ctl_allowed)
            begin
                run_bit_ff       <= wbyte_ff[`CTL_RUN];
                force_run_bit_ff <= wbyte_ff[`CTL_FORCE];
                if (wbyte_ff[`CTL_RST_EN])
                    reset_on_timeout_enable_ff <= 1'b1;
            end
            if (waddr_ff == `OFS_RELOAD)
                watchdog_reload_ff <= wbyte_ff;
            if (waddr_ff == `OFS_AUX_IRQ)
                timeout_irq_enable_ff <= wbyte_ff[`AUX_IRQ_EN];
        end
    end

    // ==========================================================
    // Prescaler and counter. Refresh wins over a tick in the same cycle.
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            presc_ff <= 19'h0_0000;
            count_ff <= `RELOAD_RST;
        end
        else if (refresh)
        begin
            presc_ff <= 19'h0_0000;
            count_ff <= watchdog_reload_ff;
        end
        else if (running)
        begin
            presc_ff <= tick ? 19'h0_0000 : presc_ff + 19'h0_0001;
            if (ovf_evt)
                count_ff <= watchdog_reload_ff;
            else if (tick)
                count_ff <= count_ff + 8'h01;
        end
    end

    // ==========================================================
    // Sticky overflow flag: a new overflow beats a same-cycle clear.
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            overflow_status_flag_ff <= 1'b0;
        else if (ovf_evt)
            overflow_status_flag_ff <= 1'b1;
        else if (wr_ctl && ctl_allowed && wbyte_ff[`CTL_OVF])
            overflow_status_flag_ff <= 1'b0;
    end

    // ==========================================================
    // Chip reset request: held from the cause until one clock after the next watchdog tick while
    // running (two clocks when stopped), so after an overflow a running core sees a full tick of reset.
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_hold_ff <= 1'b0;
            rst_tick_ff <= 2'h0;
        end
        else if ((ovf_evt && wdog_mode) || key_fault)
        begin
            rst_hold_ff <= 1'b1;
            rst_tick_ff <= 2'h0;
        end
        else if (rst_hold_ff)
        begin
            if (rst_tick_ff == 2'(`RST_HOLD_TICK))
                rst_hold_ff <= 1'b0;
            else if (presc_ff == 19'(PRESCALE - 1) || !running)
                rst_tick_ff <= rst_tick_ff + 2'h1;
        end
    end
    assign wdog_reset_req = rst_hold_ff;
    // Interrupt only in timer mode; it is a level cleared with the flag.
    assign timeout_irq    = overflow_status_flag_ff & timeout_irq_enable_ff
                            & ~wdog_mode;
    assign irq_vector     = `IRQ_VECTOR;
    assign irq_priority   = `IRQ_PRIO;

    // ==========================================================
    // Assertions.
    sequence s_wdog_ovf;
        ovf_evt && wdog_mode;
    endsequence
    sequence s_reset_up;
        ##1 wdog_reset_req;
    endsequence

    property p_wdog_reset;
        @(posedge core_clk) disable iff (!resetn)
        s_wdog_ovf |-> s_reset_up;
    endproperty
    a_wdog_reset: assert property (p_wdog_reset) else $error("no reset on overflow");

    property p_timer_irq;
        @(posedge core_clk) disable iff (!resetn)
        (ovf_evt && !wdog_mode && timeout_irq_enable_ff && !wr_ctl)
            |=> timeout_irq && !wdog_reset_req;
    endproperty
    a_timer_irq: assert property (p_timer_irq) else $error("timer irq missing");

    property p_sticky_en;
        @(posedge core_clk) disable iff (!resetn)
        reset_on_timeout_enable_ff |=> reset_on_timeout_enable_ff;
    endproperty
    a_sticky_en: assert property (p_sticky_en) else $error("reset enable dropped");

    property p_force_runs;
        @(posedge core_clk) disable iff (!resetn)
        (force_run_bit_ff && !power_down && !refresh && wdog_mode && !tick)
            |=> presc_ff == $past(presc_ff) + 19'h0_0001;
    endproperty
    a_force_runs: assert property (p_force_runs) else $error("forced run stalled");

    property p_refresh;
        @(posedge core_clk) disable iff (!resetn)
        refresh |=> (count_ff == $past(watchdog_reload_ff)) && (presc_ff == 19'h0_0000);
    endproperty
    a_refresh: assert property (p_refresh) else $error("refresh did not reload");

    property p_flag_set;
        @(posedge core_clk) disable iff (!resetn)
        ovf_evt |=> overflow_status_flag_ff;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("overflow flag not set");

    property p_reload_ovf;
        @(posedge core_clk) disable iff (!resetn)
        (ovf_evt && !refresh) |=> count_ff == $past(watchdog_reload_ff);
    endproperty
    a_reload_ovf: assert property (p_reload_ovf) else $error("no reload on overflow");

    property p_key_fault;
        @(posedge core_clk) disable iff (!resetn)
        key_fault |=> wdog_reset_req [*2];
    endproperty
    a_key_fault: assert property (p_key_fault) else $error("bad key not reset");

    property p_pd_halt;
        @(posedge core_clk) disable iff (!resetn)
        (power_down && !refresh) |=> $stable(presc_ff) && $stable(count_ff);
    endproperty
    a_pd_halt: assert property (p_pd_halt) else $error("counted in power-down");

    property p_count_step;
        @(posedge core_clk) disable iff (!resetn)
        (tick && !ovf_evt && !refresh) |=> count_ff == $past(count_ff) + 8'h01;
    endproperty
    a_count_step: assert property (p_count_step) else $error("bad count step");
endmodule // programmable_watchdog_counter

//--- rtl/wdog_params.svh
`ifndef WDOG_PARAMS_SVH
`define WDOG_PARAMS_SVH
// ==========================================================
// Register byte offsets.
`define OFS_CONTROL   8'h00
`define OFS_RELOAD    8'h04
`define OFS_KEY_ONE   8'h08
`define OFS_KEY_ZERO  8'h0C
`define OFS_AUX_IRQ   8'h10
// ==========================================================
// Control and auxiliary interrupt field positions.
`define CTL_RUN       0
`define CTL_REFRESH   1
`define CTL_OVF       2
`define CTL_RST_EN    3
`define CTL_FORCE     6
`define AUX_IRQ_EN    6
// ==========================================================
// Key values, reset values, count limit, answers.
`define KEY_ONE_VAL   8'hFD
`define KEY_ZERO_VAL  8'h2A
`define RELOAD_RST    8'h00
`define CNT_MAX       8'hFF
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
// ==========================================================
// Interrupt vector and default priority level.
`define IRQ_VECTOR    16'h0053
`define IRQ_PRIO      2'h2
// ==========================================================
// Timing: crystal periods per count, and reset hold in ticks.
`define PRESCALE_CLKS 344064
`define RST_HOLD_TICK 1
`endif

//--- rtl/wdog_pkg.sv
package wdog_pkg;
    // Progress through the two-write key sequence.
    typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_ONE, KEY_ARMED} key_state_t;
endpackage

//--- verif/programmable_watchdog_counter_test.sv
`timescale 1ns/1ps
`include "wdog_params.svh"
module programmable_watchdog_counter_test;
    // ====================
    // Short names and the shortened prescaler.
    localparam int         P   = 8;
    localparam logic [7:0] CTL = `OFS_CONTROL;
    localparam logic [1:0] OK  = `RESP_OKAY;
    // ====================
    // Design ports.
    logic        core_clk, resetn;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, irq_priority;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic        idle_mode, power_down, clock_gate_off, wdog_reset_req, timeout_irq;
    logic [15:0] irq_vector;
    // ====================
    // Bench state: notes of expected answers and counters.
    logic [1:0]  exp_b[$];
    logic [33:0] exp_r[$];
    int          n_fail, n_checks, q, k, t0, t1, t2, e;
    int          cyc   = 0;
    int          n_req = 0;
    logic        req_q = 1'b0;
    logic [7:0]  r;

    programmable_watchdog_counter #(.PRESCALE(P)) DUT (
        .core_clk(core_clk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .idle_mode(idle_mode), .power_down(power_down),
        .clock_gate_off(clock_gate_off), .wdog_reset_req(wdog_reset_req),
        .timeout_irq(timeout_irq), .irq_vector(irq_vector), .irq_priority(irq_priority));

    // Free-running 100 MHz clock.
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Compare one value; an unknown matches only an unknown.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d.", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Watcher: takes the oldest note at each answer, and counts reset requests.
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        req_q <= wdog_reset_req;
        if (wdog_reset_req && !req_q)
            n_req <= n_req + 1;
        if (bvalid && bready)
            check({30'h0, bresp}, {30'h0, exp_b.pop_front()});
        if (rvalid && rready)
        begin
            check({30'h0, rresp}, {30'h0, exp_r[0][33:32]});
            check(rdata, exp_r[0][31:0]);
            exp_r.delete(0);
        end
    end

    // AXI4-Lite write; each channel is held until its own handshake edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] rs);
        int   n;
        logic a_d, w_d, b_d, a_g, w_g, b_g;
        exp_b.push_back(rs);
        // Let one edge pass, so back-to-back calls never drive a signal twice in one step.
        @(posedge core_clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        {a_d, w_d, b_d} = 3'b000;
        for (n = 0; n < 40 && !b_d; n++)
        begin
            // Ready levels are stable between edges, so look at the falling edge.
            @(negedge core_clk);
            a_g = awready;
            w_g = wready;
            b_g = bvalid;
            @(posedge core_clk);
            a_d = a_d | a_g;
            w_d = w_d | w_g;
            b_d = b_d | b_g;
            awvalid <= !a_d;
            wvalid <= !w_d;
            bready <= !b_d;
        end
        if (!b_d)
        begin
            n_fail++;
            report_and_stop();
        end
    endtask

    // AXI4-Lite read; the note holds the expected response and data.
    task automatic rd(input logic [7:0] a, input logic [1:0] rs, input logic [7:0] d);
        int   n;
        logic a_d, r_d, a_g, r_g;
        exp_r.push_back({rs, 24'h0, d});
        // Let one edge pass, so back-to-back calls never drive a signal twice in one step.
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        {a_d, r_d} = 2'b00;
        for (n = 0; n < 40 && !r_d; n++)
        begin
            @(negedge core_clk);
            a_g = arready;
            r_g = rvalid;
            @(posedge core_clk);
            a_d = a_d | a_g;
            r_d = r_d | r_g;
            arvalid <= !a_d;
            rready <= !r_d;
        end
        if (!r_d)
        begin
            n_fail++;
            report_and_stop();
        end
    endtask

    // Two-write unlock ahead of a control write.
    task automatic key();
        wr(`OFS_KEY_ONE, `KEY_ONE_VAL, OK);
        wr(`OFS_KEY_ZERO, `KEY_ZERO_VAL, OK);
    endtask

    // Bounded wait for reset request (sel=1) or interrupt to reach a level.
    task automatic wait_for(input bit sel, input logic lvl, input int lim, output int t);
        int n;
        for (n = 0; n < lim; n++)
        begin
            @(negedge core_clk);
            if ((sel ? wdog_reset_req : timeout_irq) === lvl)
                break;
        end
        t = cyc;
        if (n >= lim)
        begin
            n_fail++;
            report_and_stop();
        end
        @(posedge core_clk);
    endtask

    // ====================
    // Main sequence.
    initial
    begin
        {resetn, awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready} = '0;
        {arvalid, rready, idle_mode, power_down, clock_gate_off} = '0;
        n_fail = 0;
        n_checks = 0;
        void'($urandom(26582));
        // A short random reload keeps each period between 40 and 64 clocks.
        r = 8'hF8 + 8'($urandom % 4);
        e = (256 - r) * P;
        q = e;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        check({16'h0, irq_vector}, {16'h0, `IRQ_VECTOR});
        check({30'h0, irq_priority}, {30'h0, `IRQ_PRIO});
        rd(CTL, OK, 8'h00);
        rd(`OFS_RELOAD, OK, `RELOAD_RST);
        rd(`OFS_KEY_ONE, OK, 8'h00);
        rd(`OFS_KEY_ZERO, OK, 8'h00);
        rd(8'h14, `RESP_SLVERR, 8'h00);
        wr(8'h14, 8'h55, `RESP_SLVERR);
        // Timer mode: no key needed, interrupt on overflow, automatic reload.
        wr(`OFS_AUX_IRQ, 8'h40, OK);
        wr(`OFS_RELOAD, r, OK);
        rd(`OFS_RELOAD, OK, r);
        idle_mode <= 1'b1;
        wr(CTL, 8'h03, OK);
        t0 = cyc;
        wait_for(0, 1, q + 20, t1);
        check({31'h0, (t1 - t0 >= q - 4) && (t1 - t0 <= q + 4)}, 1);
        check({31'h0, wdog_reset_req}, 32'h0);
        rd(CTL, OK, 8'h05);
        wr(CTL, 8'h05, OK);
        check({31'h0, timeout_irq}, 32'h0);
        wait_for(0, 1, q + 4, t2);
        check(t2 - t1, q);
        wr(`OFS_AUX_IRQ, 8'h00, OK);
        check({31'h0, timeout_irq}, 32'h0);
        wr(CTL, 8'h04, OK);
        repeat (2 * q) @(posedge core_clk);
        rd(CTL, OK, 8'h00);
        // Power-down, then the clock gate, each holds the counter.
        wr(`OFS_AUX_IRQ, 8'h40, OK);
        for (k = 0; k < 2; k++)
        begin
            power_down <= (k == 0);
            clock_gate_off <= (k == 1);
            wr(CTL, 8'h03, OK);
            repeat (2 * q) @(posedge core_clk);
            rd(CTL, OK, 8'h01);
            power_down <= 1'b0;
            clock_gate_off <= 1'b0;
            wait_for(0, 1, q + 8, t1);
            wr(CTL, 8'h04, OK);
        end
        // Watchdog mode: timely keyed refreshes keep the chip out of reset.
        wr(CTL, 8'h08, OK);
        rd(CTL, OK, 8'h08);
        t0 = n_req;
        for (k = 0; k < 6; k++)
        begin
            key();
            wr(CTL, 8'h0B, OK);
            repeat (q / 2) @(posedge core_clk);
        end
        check(n_req, t0);
        rd(CTL, OK, 8'h09);
        wait_for(1, 1, q + 8, t1);
        rd(CTL, OK, 8'h0D);
        wait_for(1, 0, P + 8, t2);
        check({31'h0, t2 - t1 >= P}, 1);
        key();
        wr(CTL, 8'h0C, OK);
        rd(CTL, OK, 8'h08);
        // Unkeyed control write, wrong key value, key zero alone: each resets.
        for (k = 0; k < 3; k++)
        begin
            t0 = n_req;
            if (k == 0)
                wr(CTL, 8'h00, OK);
            else if (k == 1)
                wr(`OFS_KEY_ONE, 8'($urandom % 8'hFD), OK);
            else
                wr(`OFS_KEY_ZERO, `KEY_ZERO_VAL, OK);
            repeat (2) @(posedge core_clk);
            check(n_req, t0 + 1);
            wait_for(1, 0, 8, t1);
            rd(CTL, OK, 8'h08);
        end
        // Forced running needs no run bit.
        key();
        wr(CTL, 8'h4A, OK);
        wait_for(1, 1, q + 8, t1);
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        check({31'h0, wdog_reset_req}, 32'h0);
        rd(CTL, OK, 8'h00);
        repeat (2) @(posedge core_clk);
        check(exp_r.size() + exp_b.size(), 0);
        report_and_stop();
    end
endmodule // programmable_watchdog_counter_test
